/* File: src/ath_device.sv */
// device end: pio/dma answer logic, iordy waits, ultra dma data-out
module ath_device
  import ath_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
)
(
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // async reset
  ath_if.dev               bus,       // ata link
  input  wire logic        dmaReq,    // user wants dma
  input  wire logic        dmaWrite,  // dma host-to-device
  input  wire logic        udmaSel,   // dma is ultra dma
  input  wire logic [2:0]  udmaMode,  // ultra dma mode
  input  wire logic        cfa8,      // 8-bit transfers
  input  wire logic [15:0] rdData,    // word to host
  input  wire logic        rdValid,   // rdData valid
  output logic             rdReady,   // rdData taken
  output logic      [15:0] wrData,    // word from host
  output logic             wrValid,   // wrData valid
  input  wire logic        wrReady,   // user takes wrData
  output logic             regStrobe, // register access pulse
  output logic             regWrite,  // access is a write
  output logic      [4:0]  regAddr,   // {csN, da}
  output logic      [15:0] regWrData, // register write data
  input  wire logic [15:0] regRdData  // register read data
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed
  {
    logic [1:0] csN;
    logic [2:0] da;
    logic       diorN;
    logic       diowN;
    logic       dmackN;
  } ath_pins_t;

  typedef enum logic [1:0]
  {
    DV_REL  = 2'b00,
    DV_NEG  = 2'b01,
    DV_AST  = 2'b10,
    DV_UDMA = 2'b11
  } ath_dev_st_t;

  ath_pins_t   pinS1_reg;
  ath_pins_t   pinS2_reg;
  ath_pins_t   pinPrev_reg;
  logic [15:0] ddS1_reg;
  logic [15:0] ddS2_reg;
  ath_dev_st_t st_reg;
  logic [7:0]  cnt_reg;
  logic        rdPend_reg;
  logic [15:0] ddOut_reg;
  logic        ddDrive_reg;
  logic        dmarq_reg;
  logic        burst_reg;
  logic        pause_reg;
  logic [7:0]  rpCnt_reg;
  logic        regStrobe_reg;
  logic        regWrite_reg;
  logic [4:0]  regAddr_reg;
  logic [15:0] regWrData_reg;

  logic          rdS;
  logic          ackS;
  logic          stopS;
  logic          udmaOn;
  logic          quiet;
  logic          dataSel;
  logic          rdStart;
  logic          wrStart;
  logic          wrEnd;
  logic          hsEdge;
  logic          push;
  logic          fifoRdy;
  logic [CW-1:0] fifoCnt;
  logic [CW-1:0] room;
  logic [15:0]   fifoIn;
  logic          needWait;
  logic          waitDone;
  logic          endNow;
  logic          dmaCond;

  function automatic logic [15:0] lane(input logic [15:0] d, input logic n);
    return n ? {8'h00, d[7:0]} : d;
  endfunction

  // two flops on every pin before use
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinS1_reg   <= '1;
      pinS2_reg   <= '1;
      pinPrev_reg <= '1;
      ddS1_reg    <= '0;
      ddS2_reg    <= '0;
    end
    else
    begin
      pinS1_reg   <= {bus.csN, bus.da, bus.diorN, bus.diowN, bus.dmackN};
      pinS2_reg   <= pinS1_reg;
      pinPrev_reg <= pinS2_reg;
      ddS1_reg    <= bus.dd;
      ddS2_reg    <= ddS1_reg;
    end
  end

  assign rdS     = !pinS2_reg.diorN;
  assign ackS    = !pinS2_reg.dmackN;
  assign stopS   = pinS2_reg.diowN;
  assign udmaOn  = dmarq_reg && ackS && udmaSel;
  assign quiet   = udmaOn || burst_reg;
  assign dataSel = ackS || (pinS2_reg.csN == DATA_CS_N
                   && pinS2_reg.da == DATA_REG_ADDR);
  // strobes act on edges only, so any stretch is accepted
  assign rdStart = rdS && pinPrev_reg.diorN && !quiet;
  assign wrStart = !pinS2_reg.diowN && pinPrev_reg.diowN && !quiet;
  assign wrEnd   = pinS2_reg.diowN && !pinPrev_reg.diowN && !quiet;
  assign hsEdge  = udmaOn && (pinS2_reg.diorN != pinPrev_reg.diorN);

  assign fifoIn = lane(ddS2_reg, cfa8);
  assign push   = (wrEnd && dataSel) || hsEdge;
  assign room   = CW'(FIFO_DEPTH) - fifoCnt;

  ath_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (fifoIn),
    .inValid  (push),
    .inReady  (fifoRdy),
    .outData  (wrData),
    .outValid (wrValid),
    .outReady (wrReady),
    .count    (fifoCnt)
  );

  assign needWait = dataSel && ((rdStart && !rdValid)
                    || (wrStart && !fifoRdy));
  assign waitDone = rdPend_reg ? rdValid : fifoRdy;
  assign rdReady  = dataSel && rdValid && (rdStart
                    || (st_reg == DV_NEG && rdPend_reg && rdS));

  // ready line: released, negated for a wait, briefly asserted, ultra
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg     <= DV_REL;
      cnt_reg    <= 8'h00;
      rdPend_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        DV_REL:
        begin
          if (udmaOn)
            st_reg <= DV_UDMA;
          else if (needWait)
          begin
            st_reg     <= DV_NEG;
            rdPend_reg <= rdStart;
          end
        end
        DV_NEG:
        begin
          // data is loaded on this same edge, ready follows
          if (waitDone || !(rdS || !pinS2_reg.diowN))
          begin
            st_reg  <= DV_AST;
            cnt_reg <= 8'h00;
          end
        end
        DV_AST:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 >= TC_CYC)
            st_reg <= DV_REL;
        end
        DV_UDMA:
        begin
          if (!udmaOn)
          begin
            st_reg  <= DV_AST;
            cnt_reg <= 8'h00;
          end
        end
        default:
          st_reg <= DV_REL;
      endcase
    end
  end

  // released unless waiting, briefly asserted after a wait or a burst, or inside a burst
  assign bus.iordyOeN = (st_reg == DV_REL);
  assign bus.iordyOut = (st_reg == DV_UDMA) ? pause_reg
                        : (st_reg == DV_AST);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ddOut_reg   <= 16'h0000;
      ddDrive_reg <= 1'b0;
    end
    else
    begin
      if (rdStart)
      begin
        ddDrive_reg <= 1'b1;
        if (!dataSel)
          ddOut_reg <= regRdData;
      end
      else if (!rdS || quiet)
        ddDrive_reg <= 1'b0;
      if (rdReady)
        ddOut_reg <= lane(rdData, cfa8);
    end
  end

  assign bus.ddDevOut = ddOut_reg;
  assign bus.ddDevOeN = !ddDrive_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regStrobe_reg <= 1'b0;
      regWrite_reg  <= 1'b0;
      regAddr_reg   <= 5'h00;
      regWrData_reg <= 16'h0000;
    end
    else
    begin
      regStrobe_reg <= !dataSel && (rdStart || wrEnd);
      if (!dataSel && (rdStart || wrEnd))
      begin
        regWrite_reg  <= wrEnd;
        regAddr_reg   <= {pinS2_reg.csN, pinS2_reg.da};
        regWrData_reg <= lane(ddS2_reg, cfa8);
      end
    end
  end

  assign regStrobe = regStrobe_reg;
  assign regWrite  = regWrite_reg;
  assign regAddr   = regAddr_reg;
  assign regWrData = regWrData_reg;

  assign dmaCond = dmaWrite ? (room > CW'(UD_SPARE)) : rdValid;
  assign endNow  = stopS || (pause_reg && !dmaReq
                   && rpCnt_reg >= ath_cyc(UD_TRP_NS[udmaMode]));

  // dma request and ultra dma pause control
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dmarq_reg <= 1'b0;
      burst_reg <= 1'b0;
      pause_reg <= 1'b0;
      rpCnt_reg <= 8'h00;
    end
    else
    begin
      if (dmarq_reg)
        dmarq_reg <= udmaOn ? !endNow : (dmaReq && dmaCond);
      else
        dmarq_reg <= dmaReq && dmaCond && !ackS;
      if (udmaOn)
        burst_reg <= 1'b1;
      else if (!ackS)
        burst_reg <= 1'b0;
      // keep room for two words still in flight
      pause_reg <= udmaOn && (room <= CW'(UD_SPARE) || !dmaReq);
      if (udmaOn && pause_reg && !dmaReq)
        rpCnt_reg <= (rpCnt_reg == 8'hff) ? rpCnt_reg
                     : rpCnt_reg + 8'h01;
      else
        rpCnt_reg <= 8'h00;
    end
  end

  assign bus.dmarq = dmarq_reg;
endmodule

/* File: src/ath_fifo.sv */
// word fifo with valid/ready on both sides
module ath_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH),
  localparam int CW   = $clog2(DEPTH + 1)
)
(
  input  wire logic             clk,      // system clock
  input  wire logic             rst,      // async reset
  input  wire logic [WIDTH-1:0] inData,   // fill data
  input  wire logic             inValid,  // fill valid
  output logic                  inReady,  // not full
  output logic      [WIDTH-1:0] outData,  // drain data
  output logic                  outValid, // not empty
  input  wire logic             outReady, // drain ready
  output logic      [CW-1:0]    count     // words held
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [CW-1:0]    cnt_reg;
  logic             push;
  logic             pop;

  assign inReady  = cnt_reg != CW'(DEPTH);
  assign outValid = cnt_reg != '0;
  assign outData  = mem[rdPtr_reg];
  assign count    = cnt_reg;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_reg] <= inData;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      cnt_reg   <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + AW'(1);
      if (pop)
        rdPtr_reg <= rdPtr_reg + AW'(1);
      if (push && !pop)
        cnt_reg <= cnt_reg + CW'(1);
      else if (pop && !push)
        cnt_reg <= cnt_reg - CW'(1);
    end
  end
endmodule

/* File: src/ath_host.sv */
// host end: pio and multiword dma strobes, ultra dma data-out bursts
module ath_host
  import ath_pkg::*;
(
  input  wire logic        clk,         // system clock
  input  wire logic        rst,         // async reset
  ath_if.host              bus,         // ata link
  input  ath_xfer_t        xferMode,    // dma flavour
  input  wire logic [2:0]  pioMode,     // fastest pio mode
  input  wire logic [2:0]  pioModeSlow, // slowest device mode
  input  wire logic [1:0]  dmaMode,     // multiword mode
  input  wire logic [2:0]  udmaMode,    // ultra dma mode
  input  wire logic        cfa8,        // 8-bit transfers
  input  wire logic        reqValid,    // pio request
  output logic             reqReady,    // pio request taken
  input  wire logic        reqWrite,    // pio write
  input  wire logic [1:0]  reqCs,       // chip selects, low active
  input  wire logic [2:0]  reqAddr,     // register address
  input  wire logic [15:0] reqData,     // pio write data
  input  wire logic        dmaWrite,    // dma host-to-device
  input  wire logic [15:0] dmaData,     // dma write word
  input  wire logic        dmaValid,    // dmaData valid
  output logic             dmaReady,    // dmaData taken
  input  wire logic        dmaStop,     // end ultra burst
  output logic             rspValid,    // read word pulse
  output logic      [15:0] rspData      // read word
);
  typedef enum logic [2:0]
  {
    HS_IDLE  = 3'b000,
    HS_SETUP = 3'b001,
    HS_ACT   = 3'b010,
    HS_REC   = 3'b011,
    HS_UDMA  = 3'b100,
    HS_UEND  = 3'b101
  } ath_host_st_t;

  ath_host_st_t st_reg;
  logic [7:0]   cnt_reg;
  logic [7:0]   tot_reg;
  logic [1:0]   csN_reg;
  logic [2:0]   da_reg;
  logic [4:0]   lastAddr_reg;
  logic [2:0]   pioM_reg;
  logic         diorN_reg;
  logic         diowN_reg;
  logic         dmackN_reg;
  logic [15:0]  ddOut_reg;
  logic         ddOe_reg;
  logic         isWr_reg;
  logic         isDma_reg;
  logic         pend_reg;
  logic         rspValid_reg;
  logic [15:0]  rspData_reg;
  logic         iordyS1_reg;
  logic         iordyS2_reg;
  logic         dmarqS1_reg;
  logic         dmarqS2_reg;
  logic [15:0]  ddS1_reg;
  logic [15:0]  ddS2_reg;

  logic       dmaGo;
  logic       goAct;
  logic       actDone;
  logic       recDone;
  logic       udGo;
  logic       udEnd;
  logic [7:0] actMin;
  logic [7:0] recMin;
  logic [7:0] cycMin;
  logic [7:0] setMin;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iordyS1_reg <= 1'b1;
      iordyS2_reg <= 1'b1;
      dmarqS1_reg <= 1'b0;
      dmarqS2_reg <= 1'b0;
      ddS1_reg    <= 16'h0000;
      ddS2_reg    <= 16'h0000;
    end
    else
    begin
      iordyS1_reg <= bus.iordy;
      iordyS2_reg <= iordyS1_reg;
      dmarqS1_reg <= bus.dmarq;
      dmarqS2_reg <= dmarqS1_reg;
      ddS1_reg    <= bus.dd;
      ddS2_reg    <= ddS1_reg;
    end
  end

  assign actMin = isDma_reg ? ath_cyc(MW_TD_NS[dmaMode])
                  : ath_cyc(PIO_T2_NS[pioM_reg]);
  assign recMin = isDma_reg ? (isWr_reg ? ath_cyc(MW_TKW_NS[dmaMode])
                  : ath_cyc(MW_TKR_NS[dmaMode]))
                  : ath_cyc(PIO_T2I_NS[pioM_reg]);
  assign cycMin = isDma_reg ? ath_cyc(MW_T0_NS[dmaMode])
                  : ath_cyc(PIO_T0_NS[pioM_reg]);
  assign setMin = isDma_reg ? 8'h01 : ath_cyc(PIO_T1_NS[pioM_reg]);

  assign dmaGo    = xferMode != ATH_PIO && dmarqS2_reg
                    && (!dmaWrite || dmaValid);
  assign reqReady = st_reg == HS_IDLE && !dmaGo;
  // ready is trusted only once the sample point has passed
  assign actDone  = cnt_reg >= actMin && iordyS2_reg
                    && cnt_reg >= TA_CYC + SYNC_LAG;
  assign recDone  = cnt_reg >= recMin && tot_reg >= cycMin;
  assign goAct    = (st_reg == HS_SETUP && cnt_reg + 8'h01 >= setMin)
                    || (st_reg == HS_REC && recDone && isDma_reg
                    && dmarqS2_reg && (!isWr_reg || dmaValid));
  assign udEnd    = dmaStop || !dmarqS2_reg;
  assign udGo     = st_reg == HS_UDMA && !udEnd && !pend_reg
                    && !iordyS2_reg && dmaValid
                    && cnt_reg >= ath_cyc(UD_T2CYC_NS[udmaMode] / 2);
  assign dmaReady = (goAct && isDma_reg && isWr_reg) || udGo;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg       <= HS_IDLE;
      cnt_reg      <= 8'h00;
      tot_reg      <= 8'h00;
      csN_reg      <= CS_NONE_N;
      da_reg       <= 3'h0;
      lastAddr_reg <= 5'h1f;
      pioM_reg     <= 3'h0;
      diorN_reg    <= 1'b1;
      diowN_reg    <= 1'b1;
      dmackN_reg   <= 1'b1;
      ddOut_reg    <= 16'h0000;
      ddOe_reg     <= 1'b0;
      isWr_reg     <= 1'b0;
      isDma_reg    <= 1'b0;
      pend_reg     <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == 8'hff) ? cnt_reg : cnt_reg + 8'h01;
      tot_reg <= (tot_reg == 8'hff) ? tot_reg : tot_reg + 8'h01;
      case (st_reg)
        HS_IDLE:
        begin
          cnt_reg <= 8'h00;
          if (dmaGo)
          begin
            isDma_reg  <= 1'b1;
            isWr_reg   <= dmaWrite;
            dmackN_reg <= 1'b0;
            csN_reg    <= CS_NONE_N;
            pend_reg   <= 1'b0;
            if (xferMode == ATH_UDMA)
            begin
              st_reg    <= HS_UDMA;
              diowN_reg <= 1'b0;
            end
            else
              st_reg <= HS_SETUP;
          end
          else if (reqValid)
          begin
            isDma_reg    <= 1'b0;
            isWr_reg     <= reqWrite;
            csN_reg      <= reqCs;
            da_reg       <= reqAddr;
            lastAddr_reg <= {reqCs, reqAddr};
            pioM_reg     <= ({reqCs, reqAddr} == lastAddr_reg)
                            ? pioMode : pioModeSlow;
            ddOut_reg    <= cfa8 ? {8'h00, reqData[7:0]} : reqData;
            st_reg       <= HS_SETUP;
          end
        end
        HS_ACT:
        begin
          if (actDone)
          begin
            diorN_reg <= 1'b1;
            diowN_reg <= 1'b1;
            st_reg    <= HS_REC;
            cnt_reg   <= 8'h00;
          end
        end
        HS_REC:
        begin
          if (recDone && !goAct)
          begin
            ddOe_reg   <= 1'b0;
            dmackN_reg <= 1'b1;
            csN_reg    <= CS_NONE_N;
            st_reg     <= HS_IDLE;
          end
        end
        HS_UDMA:
        begin
          if (udEnd)
          begin
            diowN_reg <= 1'b1;
            st_reg    <= HS_UEND;
          end
          else if (pend_reg)
          begin
            diorN_reg <= !diorN_reg;
            pend_reg  <= 1'b0;
            cnt_reg   <= 8'h00;
          end
          else if (udGo)
          begin
            ddOut_reg <= cfa8 ? {8'h00, dmaData[7:0]} : dmaData;
            ddOe_reg  <= 1'b1;
            pend_reg  <= 1'b1;
          end
        end
        HS_UEND:
        begin
          ddOe_reg <= 1'b0;
          if (!dmarqS2_reg)
          begin
            dmackN_reg <= 1'b1;
            diorN_reg  <= 1'b1;
            st_reg     <= HS_IDLE;
          end
        end
        default:
          st_reg <= st_reg;
      endcase
      if (goAct)
      begin
        st_reg  <= HS_ACT;
        cnt_reg <= 8'h00;
        tot_reg <= 8'h00;
        if (isWr_reg)
        begin
          diowN_reg <= 1'b0;
          ddOe_reg  <= 1'b1;
          if (isDma_reg)
            ddOut_reg <= cfa8 ? {8'h00, dmaData[7:0]} : dmaData;
        end
        else
        begin
          diorN_reg <= 1'b0;
          ddOe_reg  <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rspValid_reg <= 1'b0;
      rspData_reg  <= 16'h0000;
    end
    else
    begin
      rspValid_reg <= st_reg == HS_ACT && actDone && !isWr_reg;
      if (st_reg == HS_ACT && actDone && !isWr_reg)
        rspData_reg <= cfa8 ? {8'h00, ddS2_reg[7:0]} : ddS2_reg;
    end
  end

  assign rspValid      = rspValid_reg;
  assign rspData       = rspData_reg;
  assign bus.csN       = csN_reg;
  assign bus.da        = da_reg;
  assign bus.diorN     = diorN_reg;
  assign bus.diowN     = diowN_reg;
  assign bus.dmackN    = dmackN_reg;
  assign bus.ddHostOut = ddOut_reg;
  assign bus.ddHostOeN = !ddOe_reg;
endmodule

/* File: src/ath_if.sv */
// parallel ata link between host and device ends
interface ath_if;
  logic [1:0]  csN;
  logic [2:0]  da;
  logic        diorN;
  logic        diowN;
  logic        dmackN;
  logic        dmarq;
  logic        iordyOut;
  logic        iordyOeN;
  logic [15:0] ddHostOut;
  logic        ddHostOeN;
  logic [15:0] ddDevOut;
  logic        ddDevOeN;
  logic        iordy;
  logic [15:0] dd;

  // released lines float high through the pull-ups
  assign iordy = iordyOeN ? 1'b1 : iordyOut;
  assign dd    = !ddHostOeN ? ddHostOut :
                 (!ddDevOeN ? ddDevOut : 16'hffff);

  modport host
  (
    output csN, da, diorN, diowN, dmackN, ddHostOut, ddHostOeN,
    input  dmarq, iordy, dd
  );
  modport dev
  (
    input  csN, da, diorN, diowN, dmackN, dd,
    output dmarq, iordyOut, iordyOeN, ddDevOut, ddDevOeN
  );
endinterface

/* File: src/ath_pkg.sv */
// shared timing tables, codes and helpers for the ata transfer handshake
package ath_pkg;

  localparam int CLK_NS = 10;
  localparam int TA_NS  = 35;
  localparam int TC_NS  = 5;
  localparam int UD_SPARE = 2;

  localparam int PIO_T0_NS  [5] = '{600, 383, 240, 180, 120};
  localparam int PIO_T1_NS  [5] = '{70, 50, 30, 30, 25};
  localparam int PIO_T2_NS  [5] = '{165, 125, 100, 80, 70};
  localparam int PIO_T2I_NS [5] = '{0, 0, 0, 70, 25};
  localparam int MW_T0_NS   [3] = '{480, 150, 120};
  localparam int MW_TD_NS   [3] = '{215, 80, 70};
  localparam int MW_TKR_NS  [3] = '{50, 50, 25};
  localparam int MW_TKW_NS  [3] = '{215, 50, 25};
  localparam int UD_T2CYC_NS[6] = '{240, 160, 120, 90, 60, 40};
  localparam int UD_TRP_NS  [6] = '{160, 125, 100, 100, 100, 85};

  localparam logic [2:0] DATA_REG_ADDR = 3'h0;
  localparam logic [1:0] DATA_CS_N     = 2'h2;
  localparam logic [1:0] CS_NONE_N     = 2'h3;

  typedef enum logic [1:0]
  {
    ATH_PIO   = 2'b00,
    ATH_MWDMA = 2'b01,
    ATH_UDMA  = 2'b10
  } ath_xfer_t;

  // least time in ns to whole clock cycles, never below one
  function automatic logic [7:0] ath_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 8'h01 : c[7:0];
  endfunction

  localparam logic [7:0] TA_CYC   = ath_cyc(TA_NS);
  localparam logic [7:0] SYNC_LAG = 8'h02;
  localparam logic [7:0] TC_CYC   =
    (TC_NS / CLK_NS < 1) ? 8'h01 : 8'(TC_NS / CLK_NS);

endpackage

/* File: verif/ata_host_transfer_handshake_test.sv */
// self-checking bench joining the ata host and device ends
module ata_host_transfer_handshake_test
  import ath_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  ath_xfer_t   xm = ATH_PIO;
  logic        clk = 0, rst = 1, c8 = 0, rv = 0, rw = 0, dw = 0, dv = 0;
  logic        dq = 0, us = 0, rdV = 0, wrR = 0, rr, dr, rsv, rdy, wv, rs;
  logic [4:0]  ra;
  logic [15:0] rwd;
  logic [2:0]  pm = 3'h4, um = 3'h4, ad = 3'h0;
  logic [1:0]  dm = 2'h2, cs = 2'h3;
  logic [15:0] rd = 16'h0, dmD = 16'h0, rdD = 16'h0, rsd, wd;
  int          fails = 0, checks = 0;
  ath_if bus ();
  always #5 clk = ~clk;
  ath_host ath_host_i (.clk, .rst, .bus, .xferMode(xm), .pioMode(pm),
    .pioModeSlow(pm), .dmaMode(dm), .udmaMode(um), .cfa8(c8), .reqValid(rv),
    .reqReady(rr), .reqWrite(rw), .reqCs(cs), .reqAddr(ad), .reqData(rd),
    .dmaWrite(dw), .dmaData(dmD), .dmaValid(dv), .dmaReady(dr),
    .dmaStop(1'b0), .rspValid(rsv), .rspData(rsd));
  ath_device ath_device_i (.clk, .rst, .bus, .dmaReq(dq), .dmaWrite(dw),
    .udmaSel(us), .udmaMode(um), .cfa8(c8), .rdData(rdD), .rdValid(rdV),
    .rdReady(rdy), .wrData(wd), .wrValid(wv), .wrReady(wrR), .regStrobe(rs),
    .regWrite(), .regAddr(ra), .regWrData(rwd), .regRdData(16'h0042));
  ath_assertions ath_assertions_i (.clk, .rst, .diorN(bus.diorN),
    .diowN(bus.diowN), .dmackN(bus.dmackN), .dmarq(bus.dmarq),
    .iordy(bus.iordy), .iordyOut(bus.iordyOut), .iordyOeN(bus.iordyOeN),
    .ddDevOeN(bus.ddDevOeN));
  task automatic chk(logic [15:0] g, logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic pio(logic w, logic [4:0] a, logic [15:0] d);
    int n = 0;
    {rv, rw, cs, ad, rd} <= {1'b1, w, a, d};
    do @(posedge clk); while (!rr && ++n < 900);
    rv <= 1'b0;
    do @(posedge clk); while (!(w ? rr : rsv) && ++n < 900);
    chk(16'(n >= 900), 16'h0000);
    if (!w)
      chk(rsd, d);
  endtask
  task automatic pop(logic [15:0] e);
    int n = 0;
    do @(posedge clk); while (!wv && ++n < 900);
    chk(wd, e);
    wrR <= 1'b1;
    @(posedge clk);
    wrR <= 1'b0;
  endtask
  // device holds the read word back for dl cycles
  task automatic rdw(int dl, logic [15:0] d, logic [15:0] e);
    fork
      pio(1'b0, 5'h10, e);
      begin
        repeat (dl) @(posedge clk);
        {rdV, rdD} <= {1'b1, d};
        do @(posedge clk); while (!rdy);
        rdV <= 1'b0;
      end
    join
  endtask
  task automatic dma(logic [15:0] b);
    dq <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      {dv, dmD} <= {1'b1, b + 16'(k)};
      do @(posedge clk); while (!dr);
    end
    {dv, dq} <= 2'b00;
    for (int k = 0; k < 4; k++)
      pop(b + 16'(k));
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      pm <= 3'(m);
      pio(1'b1, 5'h10, 16'ha5c0 + 16'(m));
      pop(16'ha5c0 + 16'(m));
    end
    rdw(0, 16'h1357, 16'h1357);
    rdw(40, 16'hbeef, 16'hbeef);
    pio(1'b0, 5'h0f, 16'h0042);
    fork
      pio(1'b1, 5'h0f, 16'h1234);
      begin
        do @(posedge clk); while (!rs);
        chk(rwd, 16'h1234);
        chk(16'(ra), 16'h000f);
      end
    join
    c8 <= 1'b1;
    rdw(0, 16'h2468, 16'h0068);
    c8 <= 1'b0;
    xm <= ATH_MWDMA;
    dw <= 1'b1;
    dma(16'hd000);
    xm <= ATH_UDMA;
    us <= 1'b1;
    dma(16'he000);
    end_sim;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    end_sim;
  end
endmodule

/* File: verif/ath_assertions.sv */
// concurrent checks on the ata link
module ath_assertions
(
  input wire logic clk,      // clock
  input wire logic rst,      // reset
  input wire logic diorN,    // rd strobe
  input wire logic diowN,    // wr strobe
  input wire logic dmackN,   // dma ack
  input wire logic dmarq,    // dma req
  input wire logic iordy,    // ready
  input wire logic iordyOut, // ready drive
  input wire logic iordyOeN, // ready enable
  input wire logic ddDevOeN  // data enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_req: assert property ($fell(dmackN) |-> $past(dmarq))
    else $error("ack early");
  a_pio_noack: assert property ((!diorN || !diowN) && dmackN |=>
    dmackN || (diorN && diowN)) else $error("ack in pio");
  a_end_ready: assert property (($rose(diorN) || $rose(diowN)) &&
    dmackN |-> $past(iordy, 2)) else $error("end in wait");
  a_rd_width: assert property ($fell(diorN) && dmackN |=>
    !diorN [*6]) else $error("short read");
  a_wr_width: assert property ($fell(diowN) && dmackN |=>
    !diowN [*6]) else $error("short write");
  a_rdy_release: assert property (dmackN && $past(dmackN, 4) &&
    !iordyOeN && iordyOut |=> iordyOeN) else $error("ready held");
  a_data_first: assert property (dmackN && !diorN &&
    !iordyOeN && iordyOut |-> !ddDevOeN) else $error("no data");
  a_ack_drop: assert property (!dmarq && !dmackN |->
    ##[1:80] dmackN) else $error("ack stuck");
  c_wait: cover property ($fell(iordy) && dmackN);
  c_mw: cover property (!dmackN && !diowN);
  c_ud: cover property (!dmackN && $changed(diorN));
endmodule
